//--- fpm_debounce.sv
// one switch: three-flop synchroniser, debounce filter, one pulse per press
`timescale 1ns/10ps
module fpm_debounce #(
  parameter int CYC = fpm_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sw_i,
  output logic press_o
);
  typedef struct packed {
    logic [2:0] sync;
    logic stable;
    logic [23:0] cnt;
    logic press;
  } fpm_deb_type;
  fpm_deb_type st_ff;
  fpm_deb_type nxt_st;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sync = {st_ff.sync[1:0], sw_i};
    nxt_st.press = 1'b0;
    // change counts only once flops two and three agree
    if (st_ff.sync[2] != st_ff.sync[1] || st_ff.sync[2] == st_ff.stable)
      nxt_st.cnt = '0;
    else if (st_ff.cnt >= 24'(CYC - 1))
    begin
      nxt_st.cnt = '0;
      nxt_st.stable = st_ff.sync[2];
      nxt_st.press = st_ff.sync[2];
    end
    else
      nxt_st.cnt = st_ff.cnt + 24'h00_0001;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign press_o = st_ff.press;
  chk_single_press: assert property (@(posedge clk_i) disable iff (srst_i)
    press_o |=> !press_o)
    else $error("press pulse longer than one cycle");
endmodule

//--- fpm_menu.sv
// front panel menu controller: edit session, save prompt, indicators
`timescale 1ns/10ps
module fpm_menu #(
  parameter longint TIMEOUT_CYC = fpm_pkg::TIMEOUT_CYC,
  parameter int DEB_CYC = fpm_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sw_select_i,
  input wire logic sw_left_i,
  input wire logic sw_right_i,
  input wire logic sw_up_i,
  input wire logic sw_down_i,
  input wire logic pll_unlock_i,
  input wire logic [22:0] nv_freq_i,
  input wire logic [5:0] nv_level_i,
  input wire logic [11:0] nv_gain_i,
  input wire logic nv_mute_i,
  input wire logic nv_remote_i,
  output logic [22:0] synth_freq_o,
  output logic [5:0] input_level_item_o,
  output logic [11:0] gain_o,
  output logic tx_mute_o,
  output logic nv_write_o,
  output logic [22:0] nv_freq_o,
  output logic [5:0] nv_level_o,
  output logic [11:0] nv_gain_o,
  output logic nv_mute_o,
  output logic nv_remote_o,
  output logic [2:0] item_o,
  output logic [2:0] cursor_o,
  output logic prompt_yes_o,
  output logic in_session_o,
  output logic led_alarm_o,
  output logic led_mute_o,
  output logic led_remote_o
);
  logic p_sel;
  logic p_left;
  logic p_right;
  logic p_up;
  logic p_down;
  logic [4:0] sw_raw;
  logic [4:0] sw_press;
  assign sw_raw = {sw_down_i, sw_up_i, sw_right_i, sw_left_i, sw_select_i};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sw
      fpm_debounce #(.CYC(DEB_CYC)) u_deb (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .sw_i(sw_raw[gi]),
        .press_o(sw_press[gi])
      );
    end
  endgenerate
  assign p_sel = sw_press[0];
  assign p_left = sw_press[1];
  assign p_right = sw_press[2];
  assign p_up = sw_press[3];
  assign p_down = sw_press[4];
  typedef struct packed {
    fpm_pkg::fpm_state_type state;
    logic loaded;
    logic [2:0] item;
    logic [2:0] cursor;
    logic yes;
    logic [39:0] idle;
    logic [22:0] freq_live;
    logic [22:0] freq_edit;
    logic [5:0] level;
    logic [11:0] gain;
    logic mute;
    logic remote;
    logic freq_mute;
    logic [22:0] s_freq;
    logic [5:0] s_level;
    logic [11:0] s_gain;
    logic s_mute;
    logic s_remote;
    logic nv_write;
    logic alarm;
    logic mute_out;
    logic session;
  } fpm_menu_type;
  fpm_menu_type st_ff;
  fpm_menu_type nxt_st;
  // frequency digit weights in kHz, cursor 0 is least significant
  function automatic logic [22:0] freq_step(input logic [2:0] c);
    case (c)
      3'h0: freq_step = 23'h00_0001;
      3'h1: freq_step = 23'h00_000A;
      3'h2: freq_step = 23'h00_0064;
      3'h3: freq_step = 23'h00_03E8;
      3'h4: freq_step = 23'h00_2710;
      3'h5: freq_step = 23'h01_86A0;
      default: freq_step = 23'h00_0001;
    endcase
  endfunction
  // gain in tenths of dB: 0.1, 1, 10 dB digits
  function automatic logic signed [11:0] gain_step(input logic [2:0] c);
    case (c)
      3'h0: gain_step = 12'sd1;
      3'h1: gain_step = 12'sd10;
      3'h2: gain_step = 12'sd100;
      default: gain_step = 12'sd1;
    endcase
  endfunction
  function automatic logic [2:0] cur_max(input logic [2:0] it);
    case (it)
      fpm_pkg::ITEM_FREQ: cur_max = 3'h5;
      fpm_pkg::ITEM_GAIN: cur_max = 3'h2;
      default: cur_max = 3'h0;
    endcase
  endfunction
  logic any_press;
  logic signed [11:0] g_try;
  logic signed [12:0] out_try;
  logic [22:0] f_try;
  always_comb
  begin
    any_press = |sw_press;
    nxt_st = st_ff;
    nxt_st.nv_write = 1'b0;
    nxt_st.alarm = pll_unlock_i;
    g_try = $signed(st_ff.gain);
    f_try = st_ff.freq_edit;
    out_try = '0;
    if (!st_ff.loaded)
    begin
      // power-up reload of the non-volatile copy
      nxt_st.loaded = 1'b1;
      nxt_st.freq_live = nv_freq_i;
      nxt_st.freq_edit = nv_freq_i;
      nxt_st.level = nv_level_i;
      nxt_st.gain = nv_gain_i;
      nxt_st.mute = nv_mute_i;
      nxt_st.remote = nv_remote_i;
      nxt_st.s_freq = nv_freq_i;
      nxt_st.s_level = nv_level_i;
      nxt_st.s_gain = nv_gain_i;
      nxt_st.s_mute = nv_mute_i;
      nxt_st.s_remote = nv_remote_i;
    end
    else
    begin
      if (st_ff.state == fpm_pkg::ST_EDIT || st_ff.state == fpm_pkg::ST_PROMPT)
        nxt_st.idle = any_press ? '0 : st_ff.idle + 40'h00_0000_0001;
      else
        nxt_st.idle = '0;
      case (st_ff.state)
        fpm_pkg::ST_NORMAL:
        begin
          if (p_sel)
          begin
            nxt_st.state = fpm_pkg::ST_EDIT;
            nxt_st.item = fpm_pkg::ITEM_FREQ;
            nxt_st.cursor = '0;
            nxt_st.s_freq = st_ff.freq_live;
            nxt_st.s_level = st_ff.level;
            nxt_st.s_gain = st_ff.gain;
            nxt_st.s_mute = st_ff.mute;
            nxt_st.s_remote = st_ff.remote;
            nxt_st.freq_edit = st_ff.freq_live;
          end
        end
        fpm_pkg::ST_EDIT:
        begin
          if (p_right)
            nxt_st.cursor = (st_ff.cursor == fpm_pkg::CUR_RET) ? 3'h0 :
              (st_ff.cursor == 3'h0) ? fpm_pkg::CUR_RET : st_ff.cursor - 3'h1;
          else if (p_left)
            nxt_st.cursor = (st_ff.cursor == fpm_pkg::CUR_RET) ? cur_max(st_ff.item) :
              (st_ff.cursor == cur_max(st_ff.item)) ? fpm_pkg::CUR_RET :
              st_ff.cursor + 3'h1;
          else if (p_sel)
          begin
            if (st_ff.cursor == fpm_pkg::CUR_RET || st_ff.item == fpm_pkg::ITEM_LAST)
            begin
              nxt_st.state = fpm_pkg::ST_PROMPT;
              nxt_st.yes = 1'b1;
            end
            else
            begin
              nxt_st.item = st_ff.item + 3'h1;
              nxt_st.cursor = '0;
            end
          end
          else if ((p_up || p_down) && st_ff.cursor != fpm_pkg::CUR_RET)
          begin
            case (st_ff.item)
              fpm_pkg::ITEM_FREQ:
              begin
                f_try = p_up ? st_ff.freq_edit + freq_step(st_ff.cursor) :
                  st_ff.freq_edit - freq_step(st_ff.cursor);
                if (f_try >= fpm_pkg::FREQ_MIN && f_try <= fpm_pkg::FREQ_MAX &&
                    !(p_down && freq_step(st_ff.cursor) > st_ff.freq_edit))
                begin
                  nxt_st.freq_edit = f_try;
                  nxt_st.freq_mute = 1'b1;
                end
              end
              fpm_pkg::ITEM_LEVEL:
              begin
                // stored as attenuation magnitude; up means less attenuation
                if (p_up && st_ff.level > fpm_pkg::LEVEL_MIN)
                  nxt_st.level = st_ff.level - 6'h01;
                else if (p_down && st_ff.level < fpm_pkg::LEVEL_MAX)
                  nxt_st.level = st_ff.level + 6'h01;
              end
              fpm_pkg::ITEM_GAIN:
              begin
                g_try = p_up ? $signed(st_ff.gain) + gain_step(st_ff.cursor) :
                  $signed(st_ff.gain) - gain_step(st_ff.cursor);
                out_try = 13'(g_try) - 13'($signed({1'b0, st_ff.level}) * 13'sd10);
                if (g_try >= fpm_pkg::GAIN_MIN && g_try <= fpm_pkg::GAIN_MAX &&
                    out_try <= 13'(fpm_pkg::OUT_MAX) && out_try >= 13'(fpm_pkg::OUT_MIN))
                  nxt_st.gain = g_try;
              end
              fpm_pkg::ITEM_MUTE: nxt_st.mute = !st_ff.mute;
              fpm_pkg::ITEM_REMOTE: nxt_st.remote = !st_ff.remote;
              default: nxt_st.item = st_ff.item;
            endcase
          end
        end
        fpm_pkg::ST_PROMPT:
        begin
          if (p_up || p_down || p_left || p_right)
            nxt_st.yes = !st_ff.yes;
          else if (p_sel)
          begin
            nxt_st.state = fpm_pkg::ST_DONE;
            nxt_st.freq_mute = 1'b0;
            if (st_ff.yes)
            begin
              nxt_st.freq_live = st_ff.freq_edit;
              nxt_st.nv_write = 1'b1;
            end
            else
            begin
              nxt_st.freq_edit = st_ff.s_freq;
              nxt_st.level = st_ff.s_level;
              nxt_st.gain = st_ff.s_gain;
              nxt_st.mute = st_ff.s_mute;
              nxt_st.remote = st_ff.s_remote;
            end
          end
        end
        fpm_pkg::ST_DONE:
        begin
          if (p_sel)
            nxt_st.state = fpm_pkg::ST_NORMAL;
        end
        default: nxt_st.state = fpm_pkg::ST_NORMAL;
      endcase
      // abandon only before the final confirm press
      if ((st_ff.state == fpm_pkg::ST_EDIT || st_ff.state == fpm_pkg::ST_PROMPT) &&
          !any_press && st_ff.idle >= 40'(TIMEOUT_CYC - 1))
      begin
        nxt_st.state = fpm_pkg::ST_NORMAL;
        nxt_st.freq_mute = 1'b0;
        nxt_st.freq_edit = st_ff.s_freq;
        nxt_st.level = st_ff.s_level;
        nxt_st.gain = st_ff.s_gain;
        nxt_st.mute = st_ff.s_mute;
        nxt_st.remote = st_ff.s_remote;
      end
    end
    // derived from the next state so the outputs leave a flop with no lag
    nxt_st.mute_out = nxt_st.mute | nxt_st.freq_mute;
    nxt_st.session = (nxt_st.state != fpm_pkg::ST_NORMAL);
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_ff <= '0;
      st_ff.state <= fpm_pkg::ST_NORMAL;
      st_ff.freq_live <= fpm_pkg::FREQ_RST;
      st_ff.freq_edit <= fpm_pkg::FREQ_RST;
      st_ff.level <= fpm_pkg::LEVEL_RST;
      st_ff.gain <= fpm_pkg::GAIN_RST;
      st_ff.yes <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end
  // flops below feed outputs directly; st_ff fields are flops too
  assign synth_freq_o = st_ff.freq_live;
  assign input_level_item_o = st_ff.level;
  assign gain_o = st_ff.gain;
  assign tx_mute_o = st_ff.mute_out;
  assign nv_write_o = st_ff.nv_write;
  assign nv_freq_o = st_ff.freq_live;
  assign nv_level_o = st_ff.level;
  assign nv_gain_o = st_ff.gain;
  assign nv_mute_o = st_ff.mute;
  assign nv_remote_o = st_ff.remote;
  assign item_o = st_ff.item;
  assign cursor_o = st_ff.cursor;
  assign prompt_yes_o = st_ff.yes;
  assign in_session_o = st_ff.session;
  assign led_alarm_o = st_ff.alarm;
  assign led_mute_o = st_ff.mute_out;
  assign led_remote_o = st_ff.remote;
  chk_start_on_sel: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.state == fpm_pkg::ST_NORMAL && !p_sel |=> st_ff.state == fpm_pkg::ST_NORMAL)
    else $error("session opened without select");
  chk_freq_held: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.loaded && !(st_ff.state == fpm_pkg::ST_PROMPT && p_sel && st_ff.yes)
    |=> $stable(synth_freq_o))
    else $error("frequency applied without yes");
  chk_freq_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.state == fpm_pkg::ST_EDIT && st_ff.loaded && $changed(st_ff.freq_edit)
    |-> tx_mute_o)
    else $error("carrier not muted on frequency edit");
  chk_level_range: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.loaded && st_ff.state == fpm_pkg::ST_EDIT |->
    st_ff.level >= fpm_pkg::LEVEL_MIN && st_ff.level <= fpm_pkg::LEVEL_MAX)
    else $error("input level out of range");
  chk_level_step: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.state == fpm_pkg::ST_EDIT && $past(st_ff.state) == fpm_pkg::ST_EDIT &&
    $changed(st_ff.level) |->
    (st_ff.level == $past(st_ff.level) + 6'h01 || st_ff.level == $past(st_ff.level) - 6'h01))
    else $error("input level step not one dB");
  chk_mute_toggle: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.state == fpm_pkg::ST_EDIT && st_ff.item == fpm_pkg::ITEM_MUTE &&
    st_ff.cursor != fpm_pkg::CUR_RET && p_down && !p_sel && !p_left && !p_right
    |=> st_ff.mute != $past(st_ff.mute))
    else $error("mute did not toggle");
  chk_no_revert: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.state == fpm_pkg::ST_PROMPT && p_sel && !st_ff.yes &&
    !(p_up || p_down || p_left || p_right)
    |=> st_ff.gain == $past(st_ff.s_gain) && st_ff.level == $past(st_ff.s_level))
    else $error("no answer did not restore settings");
  chk_done_return: assert property (@(posedge clk_i) disable iff (srst_i)
    st_ff.state == fpm_pkg::ST_DONE && p_sel |=> st_ff.state == fpm_pkg::ST_NORMAL)
    else $error("select after prompt did not return");
  chk_alarm_follow: assert property (@(posedge clk_i) disable iff (srst_i)
    pll_unlock_i |=> led_alarm_o)
    else $error("alarm not raised on unlock");
endmodule

//--- fpm_operator.sv
// operator model: presses one front panel switch at a time
`timescale 1ns/10ps
module fpm_operator (
  input wire logic clk_i,
  output logic [4:0] sw_o
);
  // keys: 0 select, 1 left, 2 right, 3 up, 4 down
  initial sw_o = 5'h00;
  // released long enough that the next press is debounced on its own
  task automatic press(input int key, input int hold);
    @(negedge clk_i);
    sw_o[key] = 1'b1;
    repeat (hold) @(negedge clk_i);
    sw_o = 5'h00;
    repeat (12) @(negedge clk_i);
  endtask
endmodule

//--- fpm_pkg.sv
// package of constants and types for the front panel menu controller
package fpm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TIMEOUT_S = 12;
  localparam int DEBOUNCE_US = 10_000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam longint TIMEOUT_CYC = longint'(TIMEOUT_S) * longint'(CLK_HZ);
  localparam int FREQ_W = 23;
  localparam logic [22:0] FREQ_MIN = 23'h1E_8480;
  localparam logic [22:0] FREQ_MAX = 23'h26_25A0;
  localparam logic [22:0] FREQ_RST = 23'h1E_8480;
  localparam logic [5:0] LEVEL_MIN = 6'h0A;
  localparam logic [5:0] LEVEL_MAX = 6'h28;
  localparam logic [5:0] LEVEL_RST = 6'h14;
  localparam logic signed [11:0] GAIN_MIN = -12'sh064;
  localparam logic signed [11:0] GAIN_MAX = 12'sh12C;
  localparam logic signed [11:0] GAIN_RST = 12'sh000;
  localparam logic signed [11:0] OUT_MAX = 12'sh000;
  localparam logic signed [11:0] OUT_MIN = -12'sh0C8;
  localparam logic [2:0] ITEM_FREQ = 3'h0;
  localparam logic [2:0] ITEM_LEVEL = 3'h1;
  localparam logic [2:0] ITEM_GAIN = 3'h2;
  localparam logic [2:0] ITEM_MUTE = 3'h3;
  localparam logic [2:0] ITEM_REMOTE = 3'h4;
  localparam logic [2:0] ITEM_LAST = 3'h4;
  localparam logic [2:0] CUR_RET = 3'h7;
  typedef enum logic [4:0] {
    ST_NORMAL = 5'b0_0001,
    ST_EDIT = 5'b0_0010,
    ST_PROMPT = 5'b0_0100,
    ST_DONE = 5'b0_1000,
    ST_SAVE = 5'b1_0000
  } fpm_state_type;
endpackage

//--- front_panel_menu_controller_tb.sv
// self-checking bench for the front panel menu controller
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module front_panel_menu_controller_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic pll_unlock_i = 1'b0;
  logic [22:0] nv_freq_i = 23'h20_0B20;
  logic [5:0] nv_level_i = 6'h14;
  logic [11:0] nv_gain_i = 12'h00A;
  logic nv_mute_i = 1'b0;
  logic nv_remote_i = 1'b0;
  logic [4:0] sw;
  logic [22:0] synth_freq_o, nv_freq_o;
  logic [5:0] input_level_item_o, nv_level_o;
  logic [11:0] gain_o, nv_gain_o;
  logic [2:0] item_o, cursor_o;
  logic tx_mute_o, nv_write_o, nv_mute_o, nv_remote_o, prompt_yes_o, in_session_o;
  logic led_alarm_o, led_mute_o, led_remote_o;
  int n_errors = 0;
  int check_count = 0;
  int nv_writes = 0;

  always #5 clk_i = ~clk_i;

  fpm_operator op (.clk_i(clk_i), .sw_o(sw));

  // short debounce and idle limit keep the run brief
  fpm_menu #(.TIMEOUT_CYC(2000), .DEB_CYC(4)) dut (
    .clk_i, .srst_i, .sw_select_i(sw[0]), .sw_left_i(sw[1]), .sw_right_i(sw[2]),
    .sw_up_i(sw[3]), .sw_down_i(sw[4]), .pll_unlock_i, .nv_freq_i, .nv_level_i,
    .nv_gain_i, .nv_mute_i, .nv_remote_i, .synth_freq_o, .input_level_item_o,
    .gain_o, .tx_mute_o, .nv_write_o, .nv_freq_o, .nv_level_o, .nv_gain_o,
    .nv_mute_o, .nv_remote_o, .item_o, .cursor_o, .prompt_yes_o, .in_session_o,
    .led_alarm_o, .led_mute_o, .led_remote_o
  );

  // store strobe is one cycle wide, so count it on every edge
  always @(posedge clk_i)
    if (nv_write_o === 1'b1)
      nv_writes <= nv_writes + 1;

  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic t_reset;
    repeat (4) @(negedge clk_i);
    `CHK(synth_freq_o, 23'h20_0B20)
    `CHK(input_level_item_o, 6'h14)
    `CHK(gain_o, 12'h00A)
    `CHK(in_session_o, 1'b0)
  endtask

  task automatic t_freq_yes;
    int w;
    w = nv_writes;
    op.press(3, 10);
    `CHK(in_session_o, 1'b0)
    op.press(0, 10);
    `CHK(in_session_o, 1'b1)
    op.press(3, 10);
    `CHK(synth_freq_o, 23'h20_0B20)
    `CHK(tx_mute_o, 1'b1)
    // held well past debounce, must still count once
    op.press(1, 40);
    `CHK(cursor_o, 3'h1)
    op.press(3, 10);
    op.press(2, 10);
    `CHK(cursor_o, 3'h0)
    op.press(2, 10);
    `CHK(cursor_o, 3'h7)
    op.press(0, 10);
    `CHK(prompt_yes_o, 1'b1)
    `CHK(synth_freq_o, 23'h20_0B20)
    op.press(0, 10);
    `CHK(synth_freq_o, 23'h20_0B2B)
    `CHK(nv_freq_o, 23'h20_0B2B)
    `CHK(nv_writes, w + 1)
    `CHK(tx_mute_o, 1'b0)
    `CHK(in_session_o, 1'b1)
    op.press(0, 10);
    `CHK(in_session_o, 1'b0)
  endtask

  task automatic t_freq_no;
    op.press(0, 10);
    op.press(4, 10);
    `CHK(tx_mute_o, 1'b1)
    `CHK(synth_freq_o, 23'h20_0B2B)
    // level edit acts live, then must be undone by the no answer
    op.press(0, 10);
    op.press(3, 10);
    `CHK(input_level_item_o, 6'h13)
    op.press(2, 10);
    `CHK(cursor_o, 3'h7)
    op.press(0, 10);
    op.press(4, 10);
    `CHK(prompt_yes_o, 1'b0)
    op.press(0, 10);
    `CHK(synth_freq_o, 23'h20_0B2B)
    `CHK(tx_mute_o, 1'b0)
    `CHK(input_level_item_o, 6'h14)
    op.press(0, 10);
    `CHK(in_session_o, 1'b0)
  endtask

  task automatic t_level_gain;
    int i;
    op.press(0, 10);
    op.press(0, 10);
    `CHK(item_o, 3'h1)
    op.press(3, 10);
    `CHK(input_level_item_o, 6'h13)
    op.press(4, 10);
    `CHK(input_level_item_o, 6'h14)
    op.press(3, 10);
    // session outlives one idle period, so the timer must restart on presses
    repeat (1500) @(negedge clk_i);
    op.press(0, 10);
    `CHK(item_o, 3'h2)
    op.press(3, 10);
    `CHK(gain_o, 12'h00B)
    op.press(1, 10);
    op.press(3, 10);
    `CHK(gain_o, 12'h015)
    op.press(1, 10);
    op.press(3, 10);
    `CHK(gain_o, 12'h079)
    op.press(3, 10);
    `CHK(gain_o, 12'h079)
    op.press(4, 10);
    op.press(4, 10);
    `CHK(gain_o, 12'h015)
    repeat (1900) @(negedge clk_i);
    `CHK(in_session_o, 1'b1)
    for (i = 0; i < 300 && in_session_o !== 1'b0; i++)
      @(negedge clk_i);
    if (in_session_o !== 1'b0)
    begin
      n_errors++;
      wrap_up();
    end
    `CHK(gain_o, 12'h00A)
    `CHK(input_level_item_o, 6'h14)
  endtask

  task automatic t_mute_remote;
    op.press(0, 10);
    repeat (3) op.press(0, 10);
    `CHK(item_o, 3'h3)
    op.press(3, 10);
    `CHK(tx_mute_o, 1'b1)
    `CHK(led_mute_o, 1'b1)
    op.press(3, 10);
    `CHK(led_mute_o, 1'b0)
    op.press(4, 10);
    `CHK(led_mute_o, 1'b1)
    op.press(0, 10);
    op.press(4, 10);
    `CHK(led_remote_o, 1'b1)
    op.press(0, 10);
    `CHK(prompt_yes_o, 1'b1)
    op.press(0, 10);
    `CHK(nv_mute_o, 1'b1)
    `CHK(nv_remote_o, 1'b1)
    `CHK(nv_gain_o, 12'h00A)
    `CHK(nv_level_o, 6'h14)
    op.press(0, 10);
    `CHK(in_session_o, 1'b0)
    `CHK(led_mute_o, 1'b1)
  endtask

  task automatic t_alarm;
    pll_unlock_i = 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK(led_alarm_o, 1'b1)
    pll_unlock_i = 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK(led_alarm_o, 1'b0)
  endtask

  initial
  begin
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    t_reset();
    t_freq_yes();
    t_freq_no();
    t_level_gain();
    t_mute_remote();
    t_alarm();
    wrap_up();
  end
endmodule
